// ===== hdl/timer_watchdog_unit.sv
// Purpose: periodic timer with prescaler and an 8-bit service watchdog
// Assumes: slow_clock is a level synchronous to clk, much slower than clk
// Notes: error request holds until the device reset arrives
`timescale 1ns/1ps
`include "twu_defines.svh"

module timer_watchdog_unit #(
	parameter int PRESET_W = 16,
	parameter int WD_W = 8,
	parameter int PRE_W = 5
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic slow_clock,
	input wire twu_pkg::power_mode_type power_mode,
	input wire logic [3:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	output logic timer_irq,
	output logic timer_underflow_pulse,
	output logic prescaled_tick,
	output logic watchdog_reset
);
	import twu_pkg::*;

	// ==========================================================
	// functions

	// low bits of the prescaler that must all be set for a tick
	function automatic logic [PRE_W-1:0] div_mask(input logic [2:0] sel);
		logic [PRE_W-1:0] m;
		m = '1;
		case (sel)
			3'h0: m = 5'h00;
			3'h1: m = 5'h01;
			3'h2: m = 5'h03;
			3'h3: m = 5'h07;
			3'h4: m = 5'h0f;
			3'h5: m = 5'h1f;
			default: m = 5'h1f; // reserved codes run as the slowest rate
		endcase
		return m;
	endfunction

	// ==========================================================
	// state
	logic slow_q_reg, restart_reg, serviced_reg;
	logic terminal_count_flag, timer_irq_enable;
	logic [PRE_W-1:0] pre_cnt_reg;
	logic [2:0] prescale_select;
	logic [5:0] watchdog_config_reg;
	logic [PRESET_W-1:0] timer_preset_reg, timer_cnt_reg;
	logic [WD_W-1:0] watchdog_count_reg, wd_cnt_reg;
	wd_state_type wd_state_reg;
	logic running, active, slow_edge, slow_fall, tick_event;
	logic [PRESET_W-1:0] timer_next;
	logic uf_event, wd_event, match_ok, service, wd_error;
	logic lock_cfg, lock_pre, lock_tmr, lock_wdc;
	logic match_service_select, watchdog_clock_select;
	logic wr_cfg, wr_pre, wr_preset, wr_csr, wr_wdc, wr_match;

	// ==========================================================
	// decode of mode, locks and writes

	// halt freezes every counter while leaving state untouched
	assign running = (power_mode != mode_halt);
	assign active = (power_mode == mode_active);

	assign lock_cfg = watchdog_config_reg[`CFG_LOCK_CFG];
	assign lock_pre = watchdog_config_reg[`CFG_LOCK_PRE];
	assign lock_tmr = watchdog_config_reg[`CFG_LOCK_TMR];
	assign lock_wdc = watchdog_config_reg[`CFG_LOCK_WDC];
	assign watchdog_clock_select = watchdog_config_reg[`CFG_WD_CLK_SEL];
	assign match_service_select = watchdog_config_reg[`CFG_MATCH_SEL];

	// only the match register takes writes in idle and save modes; nothing answers in halt
	assign wr_cfg = wr && active && addr == `TWU_CFG_OFS && !lock_cfg;
	assign wr_pre = wr && active && addr == `TWU_PRE_OFS && !lock_pre;
	assign wr_preset = wr && active && addr == `TWU_PRESET_OFS
		&& !lock_tmr;
	assign wr_csr = wr && active && addr == `TWU_CSR_OFS && !lock_tmr;
	assign wr_wdc = wr && active && addr == `TWU_WATCHDOG_COUNT_REG_OFS && !lock_wdc;
	assign wr_match = wr && running && addr == `TWU_MATCH_OFS;

	assign match_ok = (wdata[7:0] == `MATCH_VALUE);

	// ==========================================================
	// prescaler

	// slow clock edges; inputs are already synchronous
	assign slow_edge = slow_clock && !slow_q_reg && running;
	assign slow_fall = !slow_clock && slow_q_reg && running;

	// tick when the low bits selected by the divisor are all ones
	assign tick_event = slow_edge
		&& ((pre_cnt_reg & div_mask(prescale_select))
		== div_mask(prescale_select));

	// slow clock sampler; held in halt so a fall missed there is still seen
	always_ff @(posedge clk) begin
		if (rst) begin
			slow_q_reg <= 1'b0;
		end else if (running) begin
			slow_q_reg <= slow_clock;
		end
	end

	// free running prescale counter
	always_ff @(posedge clk) begin
		if (rst) begin
			pre_cnt_reg <= '0;
		end else if (slow_edge) begin
			pre_cnt_reg <= pre_cnt_reg + 1'b1;
		end
	end

	// prescaler select register
	always_ff @(posedge clk) begin
		if (rst) begin
			prescale_select <= `PRE_RST;
		end else if (wr_pre) begin
			prescale_select <= wdata[2:0];
		end
	end

	// tick level: falls with the slow clock so divide-by-one still toggles
	always_ff @(posedge clk) begin
		if (rst) begin
			prescaled_tick <= 1'b0;
		end else if (tick_event) begin
			prescaled_tick <= 1'b1;
		end else if (slow_fall) begin
			prescaled_tick <= 1'b0;
		end
	end

	// ==========================================================
	// configuration register

	// lock bits only ever get set; a locked register ignores the write
	always_ff @(posedge clk) begin
		if (rst) begin
			watchdog_config_reg <= `CFG_RST;
		end else if (wr_cfg) begin
			watchdog_config_reg[5:4] <= wdata[5:4];
			watchdog_config_reg[3:0] <= watchdog_config_reg[3:0]
				| wdata[3:0];
		end
	end

	// ==========================================================
	// periodic timer

	// count value after this tick: reload at zero or on restart, else step down
	always_comb begin
		if (restart_reg || timer_cnt_reg == '0) begin
			timer_next = timer_preset_reg;
		end else begin
			timer_next = timer_cnt_reg - 1'b1;
		end
	end

	// underflow fires on the tick that brings the count to zero
	assign uf_event = tick_event && timer_next == '0;

	// preset is only sampled at reload, so a write never jolts the count
	always_ff @(posedge clk) begin
		if (rst) begin
			timer_preset_reg <= `PRESET_RST;
		end else if (wr_preset) begin
			timer_preset_reg <= wdata;
		end
	end

	// the down counter itself
	always_ff @(posedge clk) begin
		if (rst) begin
			timer_cnt_reg <= `PRESET_RST;
		end else if (tick_event) begin
			timer_cnt_reg <= timer_next;
		end
	end

	// underflow level spans one full tick period
	always_ff @(posedge clk) begin
		if (rst) begin
			timer_underflow_pulse <= 1'b0;
		end else if (tick_event) begin
			timer_underflow_pulse <= (timer_next == '0);
		end
	end

	// restart request; a new request in the clearing cycle survives
	always_ff @(posedge clk) begin
		if (rst) begin
			restart_reg <= 1'b0;
		end else if (wr_csr && wdata[`CSR_RESTART]) begin
			restart_reg <= 1'b1;
		end else if (tick_event) begin
			restart_reg <= 1'b0;
		end
	end

	// interrupt enable
	always_ff @(posedge clk) begin
		if (rst) begin
			timer_irq_enable <= 1'b0;
		end else if (wr_csr) begin
			timer_irq_enable <= wdata[`CSR_IRQ_EN];
		end
	end

	// terminal count: software writes 0 to clear, a new underflow wins
	always_ff @(posedge clk) begin
		if (rst) begin
			terminal_count_flag <= 1'b0;
		end else if (uf_event) begin
			terminal_count_flag <= 1'b1;
		end else if (wr_csr && !wdata[`CSR_TC]) begin
			terminal_count_flag <= 1'b0;
		end
	end

	// interrupt level follows the flag only while enabled
	always_ff @(posedge clk) begin
		if (rst) begin
			timer_irq <= 1'b0;
		end else begin
			timer_irq <= terminal_count_flag && timer_irq_enable;
		end
	end

	// ==========================================================
	// watchdog

	// clock source: prescaled tick or timer underflow
	assign wd_event = watchdog_clock_select ? tick_event : uf_event;

	// a service is a count write or a correct match write per the mode
	assign service = wd_state_reg == wd_run
		&& ((wr_wdc && !match_service_select)
		|| (wr_match && match_service_select && match_ok));

	// error causes: late, twice in one watchdog clock, wrong match value
	always_comb begin
		wd_error = 1'b0;
		if (wd_state_reg == wd_run) begin
			if (wd_event && wd_cnt_reg == '0 && !service) begin
				wd_error = 1'b1;
			end
			if (service && serviced_reg) begin
				wd_error = 1'b1;
			end
			if (wr_match && match_service_select && !match_ok) begin
				wd_error = 1'b1;
			end
		end
	end

	// programmed count value
	always_ff @(posedge clk) begin
		if (rst) begin
			watchdog_count_reg <= `WATCHDOG_COUNT_REG_RST;
		end else if (wr_wdc) begin
			watchdog_count_reg <= wdata[7:0];
		end
	end

	// life cycle: off until the first count or match write, then runs until an error, which holds until reset
	always_ff @(posedge clk) begin
		if (rst) begin
			wd_state_reg <= wd_off;
		end else begin
			case (wd_state_reg)
				wd_off: begin
					if (wr_wdc || wr_match) begin
						wd_state_reg <= wd_run;
					end
				end
				wd_run: begin
					if (wd_error) begin
						wd_state_reg <= wd_err;
					end
				end
				wd_err: begin
					wd_state_reg <= wd_err;
				end
				default: begin
					wd_state_reg <= wd_off;
				end
			endcase
		end
	end

	// the watchdog down counter
	always_ff @(posedge clk) begin
		if (rst) begin
			wd_cnt_reg <= '0;
		end else if (wd_state_reg == wd_off) begin
			if (wr_wdc) begin
				wd_cnt_reg <= wdata[7:0];
			end else if (wr_match) begin
				wd_cnt_reg <= watchdog_count_reg;
			end
		end else if (wd_state_reg == wd_run) begin
			if (service && match_service_select) begin
				wd_cnt_reg <= watchdog_count_reg;
			end else if (service) begin
				wd_cnt_reg <= wdata[7:0];
			end else if (wd_event && wd_cnt_reg != '0) begin
				wd_cnt_reg <= wd_cnt_reg - 1'b1;
			end
		end
	end

	// service seen with no watchdog clock since; a second is too frequent
	always_ff @(posedge clk) begin
		if (rst) begin
			serviced_reg <= 1'b0;
		end else if (service) begin
			serviced_reg <= 1'b1;
		end else if (wd_event) begin
			serviced_reg <= 1'b0;
		end
	end

	// reset request stays up until the device reset clears the unit
	always_ff @(posedge clk) begin
		if (rst) begin
			watchdog_reset <= 1'b0;
		end else if (wd_error) begin
			watchdog_reset <= 1'b1;
		end
	end

	// ==========================================================
	// read port: data one cycle after the strobe, zero otherwise

	// locked registers and registers out of reach read as zero
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata <= '0;
		end else begin
			rdata <= '0;
			if (rd && active) begin
				case (addr)
					`TWU_CFG_OFS: begin
						if (!lock_cfg) begin
							rdata <= {10'h000, watchdog_config_reg};
						end
					end
					`TWU_PRE_OFS: begin
						if (!lock_pre) begin
							rdata <= {13'h0000, prescale_select};
						end
					end
					`TWU_PRESET_OFS: begin
						if (!lock_tmr) begin
							rdata <= timer_preset_reg;
						end
					end
					`TWU_CSR_OFS: begin
						if (!lock_tmr) begin
							rdata <= {13'h0000, timer_irq_enable,
								terminal_count_flag, restart_reg};
						end
					end
					`TWU_WATCHDOG_COUNT_REG_OFS: begin
						if (!lock_wdc) begin
							rdata <= {8'h00, wd_cnt_reg};
						end
					end
					default: rdata <= '0;
				endcase
			end
		end
	end

endmodule // timer_watchdog_unit

// ===== hdl/twu_defines.svh
// Purpose: constants for the timing and watchdog unit
// Assumes: 16-bit register port, offsets are byte positions on that port
// Notes: included by the unit only; the bench side uses literal values
`ifndef TWU_DEFINES_SVH
`define TWU_DEFINES_SVH

// ==========================================================
// register offsets
`define TWU_CFG_OFS 4'h0
`define TWU_PRE_OFS 4'h2
`define TWU_PRESET_OFS 4'h4
`define TWU_CSR_OFS 4'h6
`define TWU_WATCHDOG_COUNT_REG_OFS 4'h8
`define TWU_MATCH_OFS 4'ha

// ==========================================================
// field positions
`define CFG_LOCK_CFG 0
`define CFG_LOCK_PRE 1
`define CFG_LOCK_TMR 2
`define CFG_LOCK_WDC 3
`define CFG_WD_CLK_SEL 4
`define CFG_MATCH_SEL 5
`define CSR_RESTART 0
`define CSR_TC 1
`define CSR_IRQ_EN 2

// ==========================================================
// reset values and constants
`define CFG_RST 6'h00
`define PRE_RST 3'h0
`define PRESET_RST 16'hffff
`define WATCHDOG_COUNT_REG_RST 8'h00
`define MATCH_VALUE 8'h5c
`define SAFE_SLOW_CYCLES 5

`endif

// ===== hdl/twu_pkg.sv
// Purpose: types shared by the timing and watchdog unit and its bench
// Assumes: power mode comes from the device power controller
// Notes: none
package twu_pkg;

	// ==========================================================
	// device power modes
	typedef enum logic [1:0] {
		mode_active = 2'b00,
		mode_idle = 2'b01,
		mode_save = 2'b10,
		mode_halt = 2'b11
	} power_mode_type;

	// ==========================================================
	// watchdog life cycle
	typedef enum logic [1:0] {
		wd_off = 2'b00,
		wd_run = 2'b01,
		wd_err = 2'b10
	} wd_state_type;

endpackage

// ===== bench/twu_checker_sva.sv
// Purpose: port-level checks for the timer and watchdog unit
// Assumes: one clock domain; lock and start state shadowed here
// Notes: bound to the unit at the foot of this file
`timescale 1ns/1ps
module twu_checker (
	input wire logic clk,
	input wire logic rst,
	input wire logic slow_clock,
	input wire twu_pkg::power_mode_type power_mode,
	input wire logic [3:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [15:0] rdata,
	input wire logic timer_irq,
	input wire logic timer_underflow_pulse,
	input wire logic prescaled_tick,
	input wire logic watchdog_reset
);
	import twu_pkg::*;
	logic [5:0] cfg_reg;
	logic run_reg;
	logic act;
	// ==========================================================
	// shadow state
	assign act = power_mode == mode_active;
	// lock bits only ever set, exactly as the unit keeps them
	always_ff @(posedge clk) begin
		if (rst) begin
			cfg_reg <= 6'h00;
		end else if (wr && act && addr == 4'h0 && !cfg_reg[0]) begin
			cfg_reg <= {wdata[5:4], wdata[3:0] | cfg_reg[3:0]};
		end
	end
	// a start needs a write the unit really accepts
	always_ff @(posedge clk) begin
		if (rst) begin
			run_reg <= 1'b0;
		end else if (wr && ((addr == 4'h8 && act && !cfg_reg[3])
			|| (addr == 4'ha && power_mode != mode_halt))) begin
			run_reg <= 1'b1;
		end
	end
	// ==========================================================
	// assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_reset_sticky:
		assert property (watchdog_reset |=> watchdog_reset)
		else $error("watchdog reset dropped");
	a_idle_quiet:
		assert property (!run_reg |-> !watchdog_reset)
		else $error("watchdog error before start");
	a_bad_match:
		assert property (run_reg && cfg_reg[5] && wr && addr == 4'ha
			&& power_mode != mode_halt && wdata[7:0] != 8'h5c
			|-> ##[1:2] watchdog_reset)
		else $error("wrong match value not punished");
	a_halt_freeze:
		assert property (power_mode == mode_halt |=> $stable(prescaled_tick)
			&& $stable(timer_underflow_pulse))
		else $error("unit moved in halt");
	a_uf_on_tick:
		assert property ($changed(timer_underflow_pulse)
			|-> $rose(prescaled_tick))
		else $error("underflow edge off the tick");
	a_irq_cause:
		assert property ($rose(timer_irq)
			|-> $past(timer_underflow_pulse) || $past(wr, 2))
		else $error("interrupt without cause");
	a_mode_read:
		assert property (rd && !act |=> rdata == 16'h0000)
		else $error("register readable outside active");
	a_lock_read:
		assert property (rd && ((addr == 4'h0 && cfg_reg[0])
			|| (addr == 4'h4 && cfg_reg[2])) |=> rdata == 16'h0000)
		else $error("locked register readable");
	c_underflow: cover property ($rose(timer_underflow_pulse));
	c_irq: cover property ($rose(timer_irq));
	c_wd_error: cover property ($rose(watchdog_reset));
endmodule // twu_checker

bind timer_watchdog_unit twu_checker u_chk (.clk(clk), .rst(rst),
	.slow_clock(slow_clock), .power_mode(power_mode), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.timer_irq(timer_irq), .timer_underflow_pulse(timer_underflow_pulse),
	.prescaled_tick(prescaled_tick), .watchdog_reset(watchdog_reset));

// ===== bench/timer_watchdog_unit_tb.sv
// Purpose: self-checking bench for the timer and watchdog unit
// Assumes: slow clock is a quarter of clk
// Notes: random presets, counts and modes from a fixed seed
`timescale 1ns/1ps
module timer_watchdog_unit_tb;
	import twu_pkg::*;
	logic clk = 1'b0, rst = 1'b1, slow_clock = 1'b0, wr = 1'b0, rd = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [1:0] sdiv = 2'h0;
	logic [15:0] wdata = 16'h0000, rdata;
	power_mode_type power_mode = mode_active;
	logic timer_irq, timer_underflow_pulse, prescaled_tick, watchdog_reset;
	int n_errors = 0, n_checks = 0, nt = 0, ns = 0, a, p, q;
	// ==========================================================
	// clocks and event counters
	always #12.5 clk = ~clk;
	always @(posedge clk) begin
		sdiv <= sdiv + 2'h1;
		slow_clock <= sdiv[1];
	end
	always @(posedge slow_clock) ns++;
	always @(posedge prescaled_tick) nt++;
	timer_watchdog_unit u_dut (.clk(clk), .rst(rst), .slow_clock(slow_clock),
		.power_mode(power_mode), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .timer_irq(timer_irq),
		.timer_underflow_pulse(timer_underflow_pulse),
		.prescaled_tick(prescaled_tick), .watchdog_reset(watchdog_reset));
	// ==========================================================
	// bus, compare and wait tasks
	task automatic cmp(string n, logic [15:0] e, logic [15:0] s);
		n_checks++;
		if (s !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr_t(logic [3:0] a_i, logic [15:0] d);
		@(posedge clk);
		addr <= a_i;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_t(string n, logic [3:0] a_i, logic [15:0] e);
		@(posedge clk);
		addr <= a_i;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 cmp(n, e, rdata);
	endtask
	task automatic ticks(int n);
		repeat (n) @(posedge prescaled_tick);
		#1;
	endtask
	// one underflow interval, counted in ticks from just after an underflow
	task automatic per(logic [15:0] e);
		a = nt;
		@(posedge timer_underflow_pulse);
		#1 cmp("period", e, 16'(nt - a));
	endtask
	task automatic do_rst;
		rst <= 1'b1;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
	endtask
	// slower tick keeps services clear of watchdog clock edges
	task automatic wd_setup(logic [15:0] c);
		wr_t(4'h2, 16'h0002);
		wr_t(4'h0, c);
	endtask
	task automatic late(int q_i, int l);
		ticks(q_i);
		cmp("early error", 16'h0000, 16'(watchdog_reset));
		ticks(l);
		cmp("late error", 16'h0001, 16'(watchdog_reset));
		do_rst;
	endtask
	// divisor a select code asks for; reserved codes run at 32
	function automatic logic [15:0] exp_div(int s);
		return s > 5 ? 16'h0020 : 16'h0001 << s;
	endfunction
	task automatic final_report;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// ==========================================================
	// hang guard, about 40000 clocks
	initial begin
		#1000000;
		n_errors++;
		final_report;
	end
	// ==========================================================
	// main sequence
	initial begin
		void'($urandom(32'h34871071));
		do_rst;
		rd_t("preset", 4'h4, 16'hffff);
		rd_t("cfg", 4'h0, 16'h0000);
		rd_t("unmapped", 4'hc, 16'h0000);
		for (int s = 0; s < 8; s++) begin
			wr_t(4'h2, 16'(s));
			ticks(2);
			a = ns;
			ticks(1);
			cmp("divisor", exp_div(s), 16'(ns - a));
		end
		wr_t(4'h2, 16'h0000);
		for (int i = 0; i < 4; i++) begin
			p = i == 0 ? 1 : 1 + $urandom % 12;
			wr_t(4'h4, 16'(p));
			wr_t(4'h6, 16'h0001);
			@(posedge timer_underflow_pulse);
			#1 per(16'(p + 1));
		end
		@(posedge timer_underflow_pulse);
		#1 a = nt;
		ticks(1);
		wr_t(4'h4, 16'h0005);
		@(posedge timer_underflow_pulse);
		#1 cmp("old preset", 16'(p + 1), 16'(nt - a));
		per(16'h0006);
		@(posedge timer_underflow_pulse);
		#1 a = nt;
		@(negedge timer_underflow_pulse);
		#1 cmp("width", 16'h0001, 16'(nt - a));
		wr_t(4'h6, 16'h0000);
		@(posedge timer_underflow_pulse);
		repeat (2) @(posedge clk);
		#1 cmp("irq off", 16'h0000, 16'(timer_irq));
		rd_t("flag", 4'h6, 16'h0002);
		wr_t(4'h6, 16'h0006);
		repeat (2) @(posedge clk);
		#1 cmp("irq on", 16'h0001, 16'(timer_irq));
		@(posedge timer_underflow_pulse);
		wr_t(4'h6, 16'h0004);
		repeat (2) @(posedge clk);
		#1 cmp("irq clear", 16'h0000, 16'(timer_irq));
		ticks(2);
		wr_t(4'h6, 16'h0005);
		#1 a = nt;
		@(posedge timer_underflow_pulse);
		#1 cmp("restart", 16'h0006, 16'(nt - a));
		rd_t("restart bit", 4'h6, 16'h0006);
		@(posedge clk);
		power_mode <= mode_halt;
		#1 a = nt;
		repeat (200) @(posedge clk);
		#1 cmp("halt", 16'(a), 16'(nt));
		power_mode <= mode_active;
		@(posedge timer_underflow_pulse);
		#1 per(16'h0006);
		wr_t(4'h0, 16'h0004);
		wr_t(4'h4, 16'h0009);
		rd_t("locked preset", 4'h4, 16'h0000);
		@(posedge timer_underflow_pulse);
		#1 per(16'h0006);
		wr_t(4'h0, 16'h0000);
		rd_t("lock sticky", 4'h0, 16'h0004);
		wr_t(4'h0, 16'h0001);
		rd_t("locked cfg", 4'h0, 16'h0000);
		do_rst;
		wr_t(4'h4, 16'h0003);
		rd_t("unlocked", 4'h4, 16'h0003);
		ticks(40);
		cmp("wd off", 16'h0000, 16'(watchdog_reset));
		wd_setup(16'h0010);
		q = 4 + $urandom % 8;
		wr_t(4'h8, 16'(q));
		repeat (6) begin
			ticks(2);
			wr_t(4'h8, 16'(q));
		end
		late(q - 1, 4);
		wd_setup(16'h0010);
		wr_t(4'h8, 16'h0010);
		ticks(1);
		wr_t(4'h8, 16'h0010);
		wr_t(4'h8, 16'h0010);
		repeat (2) @(posedge clk);
		#1 cmp("too often", 16'h0001, 16'(watchdog_reset));
		do_rst;
		wd_setup(16'h0030);
		wr_t(4'h8, 16'h0006);
		ticks(2);
		repeat (6) begin
			@(posedge clk);
			power_mode <= $urandom % 2 ? mode_idle : mode_save;
			ticks(3);
			wr_t(4'ha, 16'h005c);
			rd_t("idle read", 4'h4, 16'h0000);
			@(posedge clk);
			power_mode <= mode_active;
		end
		cmp("match ok", 16'h0000, 16'(watchdog_reset));
		wr_t(4'ha, 16'h005d);
		repeat (2) @(posedge clk);
		#1 cmp("bad match", 16'h0001, 16'(watchdog_reset));
		do_rst;
		wd_setup(16'h0000);
		wr_t(4'h4, 16'h0003);
		wr_t(4'h6, 16'h0001);
		wr_t(4'h8, 16'h0002);
		late(4, 20);
		final_report;
	end
endmodule // timer_watchdog_unit_tb
